// ### rtl/dsc_pkg.sv
// Constants, field layouts and state codes of the serial command controller.
// Assumes a 10 MHz system clock; the serial link clock is a separate domain.
package dsc_pkg;

	// =====================================================================
	// Frame layout and counting
	localparam int unsigned DSC_FRAME_BITS = 24;
	localparam logic [7:0]  DSC_CNT_LAST   = 8'hef;  // Counter wraps at 240, a multiple of 24
	localparam logic [7:0]  DSC_CNT_FIRST  = 8'h01;
	localparam logic [7:0]  DSC_FRAME_MOD  = 8'h18;  // 24 bits to a frame
	localparam logic [1:0]  DSC_NIBBLE_LSB = 2'h0;   // Count must be a multiple of four

	// =====================================================================
	// Command field codes
	localparam logic [3:0] DSC_OP_NOP         = 4'h0;
	localparam logic [3:0] DSC_OP_RESTORE     = 4'h1;
	localparam logic [3:0] DSC_OP_STORE_WIPER = 4'h2;
	localparam logic [3:0] DSC_OP_STORE_DATA  = 4'h3;
	localparam logic [3:0] DSC_OP_HALVE_A     = 4'h4;
	localparam logic [3:0] DSC_OP_HALVE_B     = 4'h5;
	localparam logic [3:0] DSC_OP_DEC_A       = 4'h6;
	localparam logic [3:0] DSC_OP_DEC_B       = 4'h7;
	localparam logic [3:0] DSC_OP_RELOAD      = 4'h8;
	localparam logic [3:0] DSC_OP_READ_NV     = 4'h9;
	localparam logic [3:0] DSC_OP_READ_WIPER  = 4'ha;
	localparam logic [3:0] DSC_OP_WRITE       = 4'hb;
	localparam logic [3:0] DSC_OP_DOUBLE_A    = 4'hc;
	localparam logic [3:0] DSC_OP_DOUBLE_B    = 4'hd;
	localparam logic [3:0] DSC_OP_INC_A       = 4'he;
	localparam logic [3:0] DSC_OP_INC_B       = 4'hf;

	// =====================================================================
	// Wiper and nonvolatile store
	localparam int unsigned DSC_WIPER_W  = 10;
	localparam logic [9:0]  DSC_WIPER_MID = 10'h200;  // Midscale, code 512
	localparam logic [9:0]  DSC_WIPER_MAX = 10'h3ff;
	localparam logic [9:0]  DSC_WIPER_MIN = 10'h000;
	localparam int unsigned DSC_NV_DEPTH  = 16;
	localparam int unsigned DSC_NV_W      = 16;
	localparam logic [15:0] DSC_NV_MID    = 16'h0200; // Factory default of word 0
	localparam logic [15:0] DSC_NV_BLANK  = 16'h0000;
	localparam logic [3:0]  DSC_NV_WIPER  = 4'h0;     // Word that backs the wiper
	localparam logic [5:0]  DSC_PAD_BITS  = 6'h00;

	// =====================================================================
	// Timing
	localparam int unsigned DSC_CLK_HZ        = 10_000_000;
	localparam int unsigned DSC_STORE_TIME_MS = 25;
	localparam int unsigned DSC_STORE_CYCLES  = DSC_STORE_TIME_MS * (DSC_CLK_HZ / 1000);

	// =====================================================================
	// Types
	typedef struct packed {
		logic [3:0]  command_field;
		logic [3:0]  address_field;
		logic [15:0] data_field;
	} dsc_frame_type;

	typedef struct packed {
		logic          cs_n;
		logic          tgl;
		logic [7:0]    cnt;
		dsc_frame_type word;
		logic          pr_n;
		logic          wp_n;
	} dsc_link_sync_type;

	typedef enum logic [3:0] {
		DSC_ST_INIT   = 4'b0001,
		DSC_ST_IDLE   = 4'b0010,
		DSC_ST_RDWAIT = 4'b0100,
		DSC_ST_STORE  = 4'b1000
	} dsc_state_type;

endpackage : dsc_pkg

// ### rtl/dsc_nv_mem.sv
// Nonvolatile store model: sixteen 16-bit words, one write and one read port.
// Assumes a single clock; read data come out of a register one cycle later.
`timescale 1ns/10ps

module dsc_nv_mem
	import dsc_pkg::*;
(
	input  wire logic        clk_sys_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  wr_addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic [3:0]  rd_addr_i,
	output logic      [15:0] rd_data_o
);

	// =====================================================================
	// Storage
	// Factory contents; a reset must not wipe a nonvolatile store
	// Given at the declaration so the write process stays the only writer
	logic [DSC_NV_W-1:0] mem_reg [DSC_NV_DEPTH] = '{DSC_NV_WIPER: DSC_NV_MID,
		default: DSC_NV_BLANK};

	// Write port
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem_reg[wr_addr_i] <= wr_data_i;
		end
	end

	// Registered read port
	always_ff @(posedge clk_sys_i) begin
		rd_data_o <= mem_reg[rd_addr_i];
	end

endmodule : dsc_nv_mem

// ### rtl/dsc_serial_ctrl.sv
// Serial command front end and wiper control of a 10-bit digital potentiometer.
// Assumes a serial master on the link pins and slow, clean preset and protect pins.
`timescale 1ns/10ps

// Operation
// - Wiper output follows scratchpad register only
// - Store takes 25 ms, frames locked out
// - Ready pin pulses low after store
// - Opcodes 0 to 7 decode as listed
// - Opcodes 8 to 15 decode as listed
// - Zero code puts wiper at B end
// - Opcode 0xB loads data into wiper
// - Opcode 0x2 commits wiper after store time
// - Serial output shifts previous frame's word
// - Power-on loads wiper from store, default midscale
// - Opcodes 1 and 8 reload wiper
// - Preset low forces midscale, rise reloads
// - Empty strobe repeats step or shift
// - Protect pin low blocks changes except reloads
// - Serial output released while select high
// - 24-bit frames, MSB first, select held low
// - Decode only when select returns high
// - Command, address, data fields drive operation
// - Bit counts must be multiples of 24
// - Empty strobe does nothing before the first command after power-up
// - Count not multiple of four drops the frame
// - Works in modes zero and three
// - Command, address, then data field layout
// - Opcode 1 enters read power state, opcode 0 leaves it
// - Ready marks 2, 3, 8, 9, 10, preset
// - Factory store value is midscale 512
module dsc_serial_ctrl
	import dsc_pkg::*;
#(
	parameter int unsigned STORE_CYCLES = DSC_STORE_CYCLES
) (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	input  wire logic       spi_sclk_i,
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_sdi_i,
	output logic            spi_sdo_o,
	output logic            spi_sdo_oe_n_o,
	input  wire logic       preset_reload_pin_n_i,
	input  wire logic       write_protect_n_i,
	output logic            ready_o,
	output logic            ready_oe_n_o,
	output logic [9:0]      wiper_scratchpad_o,
	output logic            read_power_o,
	output logic            store_busy_o
);

	// =====================================================================
	// Declarations
	logic          link_in_frame_reg;
	logic [23:0]   link_sr_reg;
	logic [7:0]    link_cnt_reg;
	logic          link_tgl_reg;
	logic          link_clr;
	logic          sdo_bit;

	dsc_link_sync_type sync_raw;
	dsc_link_sync_type sync1_reg;
	dsc_link_sync_type sync2_reg;
	logic          cs_hi_d_reg;
	logic          pr_hi_d_reg;
	logic          last_tgl_reg;

	dsc_state_type state_reg;
	logic [9:0]    wiper_reg;
	dsc_frame_type tx_word_reg;
	dsc_frame_type last_word_reg;
	logic          have_cmd_reg;
	logic          read_power_reg;
	logic          ready_pulse_reg;
	logic          pr_pend_reg;
	logic          rd_to_tx_reg;
	logic          rd_ready_reg;
	logic [17:0]   store_cnt_reg;
	logic          mem_we_reg;
	logic [3:0]    mem_wr_addr_reg;
	logic [15:0]   mem_wr_data_reg;
	logic [3:0]    mem_rd_addr;
	logic [15:0]   nv_rd_data;

	logic          cs_rise;
	logic          clocked;
	logic          count_ok;
	logic          new_go;
	logic          go;
	dsc_frame_type go_word;
	logic [3:0]    go_op;
	logic          wp_ok;
	logic          pr_level;
	logic          pr_rise;
	logic          idle;

	// =====================================================================
	// Decode helpers
	// Opcodes that alter the scratchpad or the store; the protect pin holds these off
	function automatic logic dsc_is_guarded(input logic [3:0] op);
		return !(op == DSC_OP_NOP || op == DSC_OP_RESTORE || op == DSC_OP_RELOAD ||
			op == DSC_OP_READ_NV || op == DSC_OP_READ_WIPER);
	endfunction : dsc_is_guarded

	// Next wiper for the step, shift and write opcodes; others keep the value
	function automatic logic [9:0] dsc_step(input logic [3:0] op, input logic [9:0] w,
		input logic [9:0] d);
		logic [9:0] r;
		r = w;
		unique case (op)
			DSC_OP_HALVE_A, DSC_OP_HALVE_B:   r = w >> 1;
			DSC_OP_DEC_A, DSC_OP_DEC_B:       r = (w == DSC_WIPER_MIN) ? w : w - 10'h001;
			DSC_OP_WRITE:                     r = d;
			DSC_OP_DOUBLE_A, DSC_OP_DOUBLE_B: r = w[9] ? DSC_WIPER_MAX : {w[8:0], 1'b0};
			DSC_OP_INC_A, DSC_OP_INC_B:       r = (w == DSC_WIPER_MAX) ? w : w + 10'h001;
			DSC_OP_NOP, DSC_OP_RESTORE, DSC_OP_STORE_WIPER, DSC_OP_STORE_DATA,
			DSC_OP_RELOAD, DSC_OP_READ_NV, DSC_OP_READ_WIPER: r = w;
		endcase
		return r;
	endfunction : dsc_step

	// =====================================================================
	// Link domain: shifting on the serial clock
	// Select high clears the frame flag, so each frame starts clean
	assign link_clr = spi_cs_n_i | ~reset_n_i;

	always_ff @(posedge spi_sclk_i or posedge link_clr) begin
		if (link_clr) begin
			link_in_frame_reg <= 1'b0;
		end else begin
			link_in_frame_reg <= 1'b1;
		end
	end

	// Rising-edge sampling serves modes 0 and 3; edges while deselected are ignored
	// The first edge preloads the previous word so it drains out MSB first
	always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link_sr_reg  <= 24'h000000;
			link_cnt_reg <= 8'h00;
			link_tgl_reg <= 1'b0;
		end else if (!spi_cs_n_i && !link_in_frame_reg) begin
			link_sr_reg  <= {tx_word_reg[22:0], spi_sdi_i};
			link_cnt_reg <= DSC_CNT_FIRST;
			link_tgl_reg <= ~link_tgl_reg;
		end else if (!spi_cs_n_i) begin
			link_sr_reg  <= {link_sr_reg[22:0], spi_sdi_i};
			link_cnt_reg <= (link_cnt_reg == DSC_CNT_LAST) ? 8'h00 : link_cnt_reg + 8'h01;
		end
	end

	// Open drain output: only ever pulls low, released while select is high
	assign sdo_bit        = link_in_frame_reg ? link_sr_reg[23] : tx_word_reg[23];
	assign spi_sdo_o      = 1'b0;
	assign spi_sdo_oe_n_o = spi_cs_n_i | sdo_bit;

	// =====================================================================
	// Crossing into the system domain
	// Count and word are static once the serial clock stops, so plain syncs suffice
	assign sync_raw = '{cs_n: spi_cs_n_i, tgl: link_tgl_reg, cnt: link_cnt_reg,
		word: link_sr_reg, pr_n: preset_reload_pin_n_i, wp_n: write_protect_n_i};

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			sync1_reg   <= '{cs_n: 1'b1, pr_n: 1'b1, wp_n: 1'b1, default: '0};
			sync2_reg   <= '{cs_n: 1'b1, pr_n: 1'b1, wp_n: 1'b1, default: '0};
			cs_hi_d_reg <= 1'b1;
			pr_hi_d_reg <= 1'b1;
		end else begin
			sync1_reg   <= sync_raw;
			sync2_reg   <= sync1_reg;
			cs_hi_d_reg <= sync2_reg.cs_n;
			pr_hi_d_reg <= sync2_reg.pr_n;
		end
	end

	// =====================================================================
	// Frame qualification, done only on the rising select edge
	assign cs_rise  = sync2_reg.cs_n & ~cs_hi_d_reg;
	assign clocked  = sync2_reg.tgl != last_tgl_reg;
	assign count_ok = (sync2_reg.cnt[1:0] == DSC_NIBBLE_LSB) &&
		((sync2_reg.cnt % DSC_FRAME_MOD) == 8'h00);
	assign idle     = state_reg == DSC_ST_IDLE;
	// A busy store swallows frames so nothing changes meanwhile
	assign new_go   = cs_rise && idle && clocked && count_ok;
	assign go       = new_go || (cs_rise && idle && !clocked && have_cmd_reg);
	assign go_word  = new_go ? sync2_reg.word : last_word_reg;
	assign go_op    = go_word.command_field;
	assign wp_ok    = sync2_reg.wp_n;
	assign pr_level = sync2_reg.pr_n;
	assign pr_rise  = pr_level & ~pr_hi_d_reg;

	// Remember the toggle of each strobe, whether the frame is used or dropped
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			last_tgl_reg  <= 1'b0;
			have_cmd_reg  <= 1'b0;
			last_word_reg <= '0;
		end else begin
			if (cs_rise) begin
				last_tgl_reg <= sync2_reg.tgl;
			end
			if (new_go) begin
				have_cmd_reg  <= 1'b1;
				last_word_reg <= sync2_reg.word;
			end
		end
	end

	// =====================================================================
	// Nonvolatile store
	// Reads of word 0 serve reloads; opcode 9 reads the addressed word
	assign mem_rd_addr = (go && go_op == DSC_OP_READ_NV) ? go_word.address_field
		: DSC_NV_WIPER;

	dsc_nv_mem u_nv_mem (
		.clk_sys_i (clk_sys_i),
		.we_i      (mem_we_reg),
		.wr_addr_i (mem_wr_addr_reg),
		.wr_data_i (mem_wr_data_reg),
		.rd_addr_i (mem_rd_addr),
		.rd_data_o (nv_rd_data)
	);

	// =====================================================================
	// Sequencer: power-on load, reads, timed stores
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_reg       <= DSC_ST_INIT;
			rd_to_tx_reg    <= 1'b0;
			rd_ready_reg    <= 1'b0;
			store_cnt_reg   <= 18'h00000;
			mem_we_reg      <= 1'b0;
			mem_wr_addr_reg <= DSC_NV_WIPER;
			mem_wr_data_reg <= DSC_NV_BLANK;
			ready_pulse_reg <= 1'b0;
		end else begin
			mem_we_reg      <= 1'b0;
			ready_pulse_reg <= 1'b0;
			unique case (state_reg)
				DSC_ST_INIT: begin
					state_reg    <= DSC_ST_RDWAIT;
					rd_to_tx_reg <= 1'b0;
					rd_ready_reg <= 1'b0;
				end
				DSC_ST_IDLE: begin
					if (pr_pend_reg && pr_level) begin
						state_reg    <= DSC_ST_RDWAIT;
						rd_to_tx_reg <= 1'b0;
						rd_ready_reg <= 1'b1;
					end else if (go) begin
						if (go_op == DSC_OP_RESTORE || go_op == DSC_OP_RELOAD ||
							go_op == DSC_OP_READ_NV) begin
							state_reg    <= DSC_ST_RDWAIT;
							rd_to_tx_reg <= go_op == DSC_OP_READ_NV;
							rd_ready_reg <= go_op != DSC_OP_RESTORE;
						end else if ((go_op == DSC_OP_STORE_WIPER ||
							go_op == DSC_OP_STORE_DATA) && wp_ok) begin
							state_reg       <= DSC_ST_STORE;
							store_cnt_reg   <= STORE_CYCLES[17:0];
							mem_wr_addr_reg <= (go_op == DSC_OP_STORE_WIPER) ? DSC_NV_WIPER
								: go_word.address_field;
							mem_wr_data_reg <= (go_op == DSC_OP_STORE_DATA &&
								go_word.address_field != DSC_NV_WIPER) ? go_word.data_field
								: {DSC_PAD_BITS, wiper_reg};
						end else if (go_op == DSC_OP_READ_WIPER) begin
							ready_pulse_reg <= 1'b1;
						end
					end
				end
				DSC_ST_RDWAIT: begin
					state_reg       <= DSC_ST_IDLE;
					ready_pulse_reg <= rd_ready_reg;
				end
				DSC_ST_STORE: begin
					// Commit only at the end of the store time
					if (store_cnt_reg == 18'h00001) begin
						state_reg       <= DSC_ST_IDLE;
						mem_we_reg      <= 1'b1;
						ready_pulse_reg <= 1'b1;
					end
					store_cnt_reg <= store_cnt_reg - 18'h00001;
				end
			endcase
		end
	end

	// Preset rise is held until the sequencer is free, set winning over clear
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			pr_pend_reg <= 1'b0;
		end else if (pr_rise) begin
			pr_pend_reg <= 1'b1;
		end else if (idle && pr_level) begin
			pr_pend_reg <= 1'b0;
		end
	end

	// =====================================================================
	// Wiper scratchpad
	// Preset low wins over everything, reloads pass the protect pin
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			wiper_reg <= DSC_WIPER_MID;
		end else if (!pr_level) begin
			wiper_reg <= DSC_WIPER_MID;
		end else if (state_reg == DSC_ST_RDWAIT && !rd_to_tx_reg) begin
			wiper_reg <= nv_rd_data[9:0];
		end else if (go && wp_ok && dsc_is_guarded(go_op)) begin
			wiper_reg <= dsc_step(go_op, wiper_reg, go_word.data_field[9:0]);
		end
	end

	// Zero code sits at the B end; the analog network reads this directly
	assign wiper_scratchpad_o = wiper_reg;

	// =====================================================================
	// Readback word and read power state
	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			tx_word_reg    <= '0;
			read_power_reg <= 1'b0;
		end else begin
			if (go) begin
				tx_word_reg <= go_word;
				if (go_op == DSC_OP_READ_WIPER) begin
					tx_word_reg.data_field <= {DSC_PAD_BITS, wiper_reg};
				end
				if (go_op == DSC_OP_RESTORE) begin
					read_power_reg <= 1'b1;
				end else if (go_op == DSC_OP_NOP) begin
					read_power_reg <= 1'b0;
				end
			end else if (state_reg == DSC_ST_RDWAIT && rd_to_tx_reg) begin
				tx_word_reg.data_field <= nv_rd_data;
			end
		end
	end

	assign read_power_o = read_power_reg;
	assign store_busy_o = state_reg == DSC_ST_STORE;
	assign ready_o      = 1'b0;
	assign ready_oe_n_o = ~ready_pulse_reg;

	// =====================================================================
	// Checks
	default clocking dsc_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!reset_n_i);

	AST_SDO_RELEASE: assert property (spi_cs_n_i |-> spi_sdo_oe_n_o)
		else $error("serial output driven while select high");
	AST_WRITE_LOAD: assert property (go && go_op == DSC_OP_WRITE && wp_ok && pr_level
		|=> wiper_reg == $past(go_word.data_field[9:0]))
		else $error("write opcode did not load wiper");
	AST_INC_SAT: assert property (go && go_op[3:1] == DSC_OP_INC_A[3:1] && wp_ok && pr_level
		&& wiper_reg == DSC_WIPER_MAX |=> wiper_reg == DSC_WIPER_MAX)
		else $error("increment wrapped past full scale");
	AST_HALVE: assert property (go && go_op == DSC_OP_HALVE_B && wp_ok && pr_level
		|=> wiper_reg == ($past(wiper_reg) >> 1))
		else $error("halve opcode gave wrong wiper");
	AST_PRESET_MID: assert property (!pr_level |=> wiper_reg == DSC_WIPER_MID)
		else $error("preset low did not force midscale");
	AST_WP_HOLD: assert property (go && !wp_ok && go_op == DSC_OP_WRITE && pr_level
		|=> $stable(wiper_reg))
		else $error("wiper changed while protected");
	AST_BAD_COUNT: assert property (cs_rise && clocked && sync2_reg.cnt[1:0] != 2'h0
		|-> !go)
		else $error("frame with bad count executed");
	AST_STORE_LOCK: assert property (state_reg == DSC_ST_STORE && pr_level
		##1 state_reg == DSC_ST_STORE && pr_level |-> $stable(wiper_reg))
		else $error("wiper changed during store");
	AST_READY_ONE: assert property (!ready_oe_n_o |=> ready_oe_n_o)
		else $error("ready pulse longer than one cycle");
	AST_RELOAD: assert property (go && go_op == DSC_OP_RELOAD && pr_level ##1 pr_level
		|=> wiper_reg == $past(nv_rd_data[9:0]))
		else $error("reload did not copy stored word");
	AST_STORE_COMMIT: assert property (mem_we_reg |-> !ready_oe_n_o
		&& $past(state_reg) == DSC_ST_STORE)
		else $error("store commit without ready pulse");

endmodule : dsc_serial_ctrl

// ### tb/dsc_spi_host.sv
// Host model for the serial link: a mode 0 or 3 master that frames words and collects SDO.
// Assumes the device's data output is open drain with a pull-up on the line.
`timescale 1ns/10ps

module dsc_spi_host (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_oe_n_i
);
	// =====================================
	// Idle link: clock starts low, then idles at the cpol level between frames
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o  = 1'b0;
	end

	// =====================================
	// Send n bits MSB first; n of zero gives an empty strobe; cpol high picks mode 3
	task automatic xfer(input logic [47:0] d, input int n, input logic cpol,
		output logic [47:0] rx);
		rx = '0;
		sclk_o = cpol; // Idle level settles while select is still high
		#24;
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b0; // Leading falling edge in mode 3
			sdi_o = d[i];
			#24;
			rx = {rx[46:0], sdo_oe_n_i}; // Pull-up reads high while released
			sclk_o = 1'b1;
			#24;
		end
		sclk_o = cpol;
		#24;
		// A strobe must outlast a system clock period to be seen at all
		if (n == 0) #300;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // Released line shows no stale value
	endtask : xfer
endmodule : dsc_spi_host

// ### tb/dsc_serial_ctrl_tb_top.sv
// Self-checking bench for the serial command controller.
// Assumes the host model drives the link; preset and protect pins come from here.
`timescale 1ns/10ps

module dsc_serial_ctrl_tb_top;
	import dsc_pkg::*;
	localparam int unsigned ST_CYC = 60; // Short store time keeps the run brief
	// Step table: bit 24 set marks an empty strobe, low 24 bits the frame sent; STEP_E holds the wiper expected
	localparam logic [24:0] STEP_W [16] = '{25'hb003fd, 25'he00000, 25'h1000000,
		25'hf00000, 25'hb00002, 25'h600000, 25'h1000000, 25'h700000, 25'hb00101,
		25'hc00000, 25'hd00000, 25'h400000, 25'h1000000, 25'h500000, 25'hb00000,
		25'h000000};
	localparam logic [9:0] STEP_E [16] = '{10'h3fd, 10'h3fe, 10'h3ff, 10'h3ff,
		10'h002, 10'h001, 10'h000, 10'h000, 10'h101, 10'h202, 10'h3ff, 10'h1ff,
		10'h0ff, 10'h07f, 10'h000, 10'h000};
	logic        clk_sys_i, reset_n_i, sclk, cs_n, sdi, sdo_oe_n, pr_n, wp_n;
	logic        rdy_oe_n, rd_pwr, busy, mode3, sdo_val, rdy_val;
	logic [9:0]  wiper;
	logic [47:0] rx;
	int          n_mismatch, checked, n_ready;

	// =====================================
	// Clock, design and host
	initial clk_sys_i = 1'b0;
	always #50 clk_sys_i = ~clk_sys_i;
	// Counted away from the launching edge so the pulse is seen settled
	always @(negedge clk_sys_i) if (rdy_oe_n === 1'b0) n_ready++;

	dsc_serial_ctrl #(.STORE_CYCLES(ST_CYC)) dut_u (
		.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .spi_sclk_i(sclk),
		.spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo_val), .spi_sdo_oe_n_o(sdo_oe_n),
		.preset_reload_pin_n_i(pr_n), .write_protect_n_i(wp_n), .ready_o(rdy_val),
		.ready_oe_n_o(rdy_oe_n), .wiper_scratchpad_o(wiper), .read_power_o(rd_pwr),
		.store_busy_o(busy));
	dsc_spi_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_oe_n_i(sdo_oe_n));

	// =====================================
	// Shared helpers
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cyc
	// Gap of six cycles covers decode latency and the minimum select-high time
	task automatic send(input logic [47:0] d, input int n);
		host_u.xfer(d, n, mode3, rx);
		cyc(6);
	endtask : send
	task automatic wrap_up();
		if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	task automatic wait_store();
		for (int i = 0; i < 300 && busy !== 1'b0; i++) cyc(1);
		if (busy !== 1'b0) begin
			n_mismatch++;
			wrap_up();
		end
		cyc(2);
	endtask : wait_store

	// =====================================
	// Scenarios
	task automatic t_power_on();
		chk("wiper", 24'(DSC_WIPER_MID), 24'(wiper));
		chk("read_power", 24'h0, 24'(rd_pwr));
		chk("sdo_oe_n", 24'h1, 24'(sdo_oe_n));
		chk("sdo_level", 24'h0, 24'(sdo_val));
		chk("ready_level", 24'h0, 24'(rdy_val));
		chk("ready_count", 24'h0, 24'(n_ready));
	endtask : t_power_on
	task automatic t_write_store();
		n_ready = 0;
		send(48'hb00100, 24);
		chk("wiper", 24'h100, 24'(wiper));
		send(48'h200000, 24);
		chk("sdo_word", 24'hb00100, rx[23:0]);
		chk("busy", 24'h1, 24'(busy));
		send(48'hb003ff, 24);
		wait_store();
		chk("wiper", 24'h100, 24'(wiper));
		chk("ready_count", 24'h1, 24'(n_ready));
		send(48'hb00050, 24);
		send(48'h800000, 24);
		chk("wiper", 24'h100, 24'(wiper));
		chk("ready_count", 24'h2, 24'(n_ready));
		send(48'hb00050, 24);
		send(48'h100000, 24);
		chk("wiper", 24'h100, 24'(wiper));
		chk("read_power", 24'h1, 24'(rd_pwr));
		send(48'h000000, 24);
		chk("read_power", 24'h0, 24'(rd_pwr));
	endtask : t_write_store
	task automatic t_steps();
		for (int i = 0; i < 16; i++) begin
			send({24'h0, STEP_W[i][23:0]}, STEP_W[i][24] ? 0 : 24);
			chk("wiper_step", 24'(STEP_E[i]), 24'(wiper));
		end
	endtask : t_steps
	task automatic t_frames();
		send(48'hb00123, 24);
		send(48'he00000, 23);
		send(48'he00000, 25);
		send(48'h0e0000, 20);
		chk("wiper", 24'h123, 24'(wiper));
		send(48'hb00111_b00222, 48);
		chk("wiper", 24'h222, 24'(wiper));
		chk("sdo_prev", 24'hb00123, rx[47:24]);
		chk("sdo_pass", 24'hb00111, rx[23:0]);
	endtask : t_frames
	task automatic t_reads();
		n_ready = 0;
		mode3 = 1'b1; // Readback and later frames run with the clock idling high
		send(48'ha00000, 24);
		send(48'h000000, 24);
		chk("sdo_wiper", 24'ha00222, rx[23:0]);
		send(48'h35beef, 24);
		wait_store();
		send(48'h950000, 24);
		send(48'h000000, 24);
		chk("sdo_store", 24'h95beef, rx[23:0]);
		chk("ready_count", 24'h3, 24'(n_ready));
	endtask : t_reads
	task automatic t_protect();
		logic [23:0] blk [3] = '{24'hb00077, 24'he00000, 24'h200000};
		send(48'hb00055, 24);
		wp_n = 1'b0;
		cyc(4);
		for (int i = 0; i < 3; i++) begin
			send({24'h0, blk[i]}, 24);
			chk("wiper", 24'h055, 24'(wiper));
			chk("busy", 24'h0, 24'(busy));
		end
		send(48'h800000, 24);
		chk("wiper", 24'h100, 24'(wiper));
		n_ready = 0;
		pr_n = 1'b0;
		cyc(4);
		chk("wiper", 24'h200, 24'(wiper));
		pr_n = 1'b1;
		cyc(8);
		chk("wiper", 24'h100, 24'(wiper));
		chk("ready_count", 24'h1, 24'(n_ready));
		send(48'h000000, 24);
		wp_n = 1'b1;
		cyc(4);
		send(48'hb00066, 24);
		chk("wiper", 24'h066, 24'(wiper));
	endtask : t_protect

	// =====================================
	// Main sequence
	initial begin
		reset_n_i = 1'b0;
		pr_n = 1'b1;
		wp_n = 1'b1;
		mode3 = 1'b0;
		n_mismatch = 0;
		checked = 0;
		n_ready = 0;
		cyc(20);
		reset_n_i = 1'b1;
		cyc(5);
		t_power_on();
		t_write_store();
		t_steps();
		t_frames();
		t_reads();
		t_protect();
		wrap_up();
	end
endmodule : dsc_serial_ctrl_tb_top
